/* test/dpio_board.sv */
// Purpose: Board model on the port pins.
// Assumes: ext values apply where ext_en is set.
// Notes: A floating pin without pull-up toggles each cycle.
`timescale 1ns/1ps
module dpio_board (
  input wire logic sys_clk,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe_n,
  input wire logic [5:0] a_pu,
  input wire logic [7:0] a_ext,
  input wire logic [7:0] a_ext_en,
  input wire logic [5:0] b_out,
  input wire logic [5:0] b_oe_n,
  input wire logic [5:0] b_ext,
  output logic [7:0] a_pin,
  output logic [5:0] b_pin
);
  logic [7:0] float_reg = 8'h5a;
  logic [7:0] pu;
  always @(posedge sys_clk) float_reg <= ~float_reg;
  assign pu = {1'b0, a_pu, 1'b0};
  // A released pin with pull-up and ext_en clear reads high.
  assign a_pin = (~a_oe_n & a_out) | (a_oe_n & a_ext_en & a_ext) | (a_oe_n & ~a_ext_en & (pu | float_reg));
  assign b_pin = (~b_oe_n & b_out) | (b_oe_n & b_ext);
endmodule // dpio_board

/* test/dpio_top_sva.sv */
// Purpose: Port checks for dpio_top.
// Assumes: One clock, srst synchronous.
// Notes: Bound below.
`timescale 1ns/1ps
module dpio_top_sva (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] key_wake_enable,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_n,
  input wire logic [5:0] key_wake_pullup_en,
  input wire logic [5:0] port_b_in,
  input wire logic [5:0] port_b_out,
  input wire logic [5:0] port_b_oe_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_pu;
    !$past(srst) |-> key_wake_pullup_en == $past(key_wake_enable);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up mismatch");
  property p_kw;
    (key_wake_pullup_en & ~port_a_oe_n[6:1]) == 6'h00;
  endproperty
  a_kw: assert property (p_kw) else $error("key wake pin driven");
  property p_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_unmap;
    reg_rd && !(reg_addr inside {16'h0000, 16'h0001, 16'h0004, 16'h0005}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_pbhi;
    reg_rd && reg_addr == 16'h0001 |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_pbhi: assert property (p_pbhi) else $error("port b data high bits set");
  property p_pbd6;
    reg_rd && reg_addr == 16'h0005 |=> !reg_rdata[6];
  endproperty
  a_pbd6: assert property (p_pbd6) else $error("port b dir bit 6 set");
  property p_dir;
    reg_wr && reg_addr == 16'h0004 |=> ##1 port_a_oe_n[7] == !$past(reg_wdata[7], 2)
      && port_a_oe_n[0] == !$past(reg_wdata[0], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("driver enable wrong");
  property p_mask;
    (port_a_out & port_a_oe_n) == 8'h00 && (port_b_out & port_b_oe_n) == 6'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("value on undriven pin");
  property p_rst;
    $past(srst) |-> port_a_oe_n == 8'hff && port_b_oe_n == 6'h3f;
  endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
endmodule // dpio_top_sva

bind dpio_top dpio_top_sva chk (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_wake_enable(key_wake_enable),
  .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
  .key_wake_pullup_en(key_wake_pullup_en), .port_b_in(port_b_in), .port_b_out(port_b_out),
  .port_b_oe_n(port_b_oe_n));

/* test/tb.sv */
// Purpose: Self-checking bench for dpio_top.
// Assumes: Board model drives the pins.
// Notes: Expectations come from int shadow registers.
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, a_ext = 8'h00, a_ext_en = 8'hff;
  logic reg_wr = 1'b0, reg_rd = 1'b0, b0;
  logic [7:0] reg_rdata, port_a_in, port_a_out, port_a_oe_n;
  logic [5:0] key_wake_enable = 6'h00, b_ext = 6'h00;
  logic [5:0] key_wake_pullup_en, port_b_in, port_b_out, port_b_oe_n;
  int mismatches = 0;
  int samples_checked = 0;
  int la, lb, da, db, kw, pa, pb, m;
  always #10 sys_clk = ~sys_clk;
  dpio_top uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_wake_enable(key_wake_enable), .port_a_in(port_a_in),
    .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n), .key_wake_pullup_en(key_wake_pullup_en),
    .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n));
  dpio_board board (.sys_clk(sys_clk), .a_out(port_a_out), .a_oe_n(port_a_oe_n), .a_pu(key_wake_pullup_en),
    .a_ext(a_ext), .a_ext_en(a_ext_en), .b_out(port_b_out), .b_oe_n(port_b_oe_n), .b_ext(b_ext),
    .a_pin(port_a_in), .b_pin(port_b_in));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end
  initial begin
    void'($urandom(32'hc0a7));
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    rd(16'h0004, 8'h00, "dir_a");
    rd(16'h0005, 8'h00, "dir_b");
    for (int i = 0; i < 6; i++) begin
      la = $urandom % 256;
      lb = $urandom % 256;
      wr(16'h0000, 8'(la));
      wr(16'h0001, 8'(lb));
      lb = lb & 63;
      da = $urandom % 256;
      db = $urandom % 128;
      wr(16'h0004, 8'(da));
      wr(16'h0005, 8'(db));
      kw = (i > 2) ? $urandom % 64 : 0;
      m = da & ~(kw << 1);
      pa = (($urandom % 256) & ~(kw << 1)) | (kw << 1);
      pb = $urandom % 64;
      key_wake_enable <= 6'(kw);
      a_ext <= 8'(pa);
      a_ext_en <= 8'(~(kw << 1));
      b_ext <= 6'(pb);
      repeat (4) @(posedge sys_clk);
      rd(16'h0004, 8'(da), "dir_a");
      rd(16'h0005, 8'(db & 191), "dir_b");
      rd(16'h0000, 8'((da & la) | (~da & pa)), "data_a");
      rd(16'h0001, 8'((db & lb) | (~db & pb)), "data_b");
      chk("a_oe_n", 8'(~m), port_a_oe_n);
      chk("a_out", 8'(la & m), port_a_out);
      chk("b_oe_n", 8'(~db | 192), {2'b11, port_b_oe_n});
      chk("b_out", 8'(db & lb), {2'b00, port_b_out});
      chk("pullup", 8'(kw), {2'b00, key_wake_pullup_en});
    end
    wr(16'h0002, 8'hff);
    rd(16'h0002, 8'h00, "unmapped");
    rd(16'h0004, 8'(da), "dir_kept");
    @(posedge sys_clk);
    key_wake_enable <= 6'h00;
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(16'h0005, 8'h00, "dir_b_rst");
    wr(16'h0004, 8'hff);
    wr(16'h0005, 8'h3f);
    rd(16'h0000, 8'(la), "latch_a_kept");
    rd(16'h0001, 8'(lb), "latch_b_kept");
    wr(16'h0005, 8'h81);
    repeat (3) @(posedge sys_clk);
    #1;
    b0 = port_b_out[0];
    @(posedge sys_clk);
    #1;
    chk("clk_out", {7'h00, ~b0}, {7'h00, port_b_out[0]});
    chk("clk_oe_n", 8'h00, {7'h00, port_b_oe_n[0]});
    close_out();
  end
endmodule // tb

/* verilog/dpio_pkg.sv */
// Purpose: Shared constants for the dual parallel I/O ports block.
// Assumes: Byte-wide register port, one system clock, synchronous reset.
// Notes: Register offsets are byte addresses on the register port.
//
// Notes on behaviour
// - Port A data register at 0x0000 holds one latch for each of eight pins and keeps its contents over reset.
// - A port A direction bit of 1 turns the pin driver on and a 0 turns it off.
// - Reset clears all eight port A direction bits so every port A pin starts as an input.
// - Reading port A data gives the latch for output pins and the sampled pin level for input pins.
// - Every data latch bit takes a write whatever its direction bit says.
// - A set key wake enable makes its port A pin an input with pull-up on and driver off, over the direction bit.
// - A key wake pin reads as the pin level only when its direction bit is 0, otherwise as the latch.
// - The pull-ups on port A pins 6 down to 1 are on only while the matching key wake enable bit is set.
// - Port B data register at 0x0001 has latches in bits 5 to 0, bits 7 and 6 absent, and keeps its contents over reset.
// - Port B direction register at 0x0005 has direction bits 5 to 0, clock out enable in bit 7, bit 6 reading 0, all cleared on reset.
// - Port A direction register at 0x0004 has eight read/write bits, one per port A pin.
// - Writing the latch of a pin whose direction bit is 0 changes only the latch, not the pin nor what it reads back.
// - Reading port B data gives the latch for output pins and the pin level for input pins.
// - With the clock out enable set, port B pin 0 carries the bus clock instead of its normal function.
package dpio_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PA_W = 8;
  localparam int PB_W = 6;
  localparam int KW_W = 6;
  localparam int KW_LO = 1;

  localparam logic [15:0] OFF_PA_LATCH = 16'h0000;
  localparam logic [15:0] OFF_PB_LATCH = 16'h0001;
  localparam logic [15:0] OFF_PA_DIR = 16'h0004;
  localparam logic [15:0] OFF_PB_DIR = 16'h0005;

  localparam int BIT_CLK_OUT_EN = 7;
  localparam int BIT_CLK_PIN = 0;

  localparam logic [7:0] RST_PA_DIR = 8'h00;
  localparam logic [5:0] RST_PB_DIR = 6'h00;
  localparam logic RST_CLK_OUT_EN = 1'b0;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  typedef enum logic [4:0] {
    SEL_NONE = 5'b00001,
    SEL_PA_LATCH = 5'b00010,
    SEL_PB_LATCH = 5'b00100,
    SEL_PA_DIR = 5'b01000,
    SEL_PB_DIR = 5'b10000
  } dpio_sel_t;

endpackage

/* verilog/dpio_port_slice.sv */
// Purpose: Per-pin read selection and driver enable for one parallel port.
// Assumes: All inputs come from registers or synchronisers on sys_clk.
// Notes: Purely combinational; the caller registers what leaves the block.
`timescale 1ns/1ps
module dpio_port_slice #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] force_in,
  input wire logic [W-1:0] pin_level,
  output logic [W-1:0] read_val,
  output logic [W-1:0] drive_en
);

  generate
    if (W < 1 || W > 8) begin : g_bad_width
      $error("dpio_port_slice width must lie between one and eight");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // The read follows the direction bit alone, even when the pin is forced to input.
      assign read_val[i] = dir[i] ? latch[i] : pin_level[i];
      assign drive_en[i] = dir[i] & ~force_in[i];
    end
  endgenerate

endmodule // dpio_port_slice

/* verilog/dpio_sync.sv */
// Purpose: Two-stage synchroniser for a bus of pin levels.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module dpio_sync #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } dpio_sync_state_t;

  dpio_sync_state_t st_reg;
  dpio_sync_state_t st_next;

  generate
    if (W < 1) begin : g_bad_width
      $error("dpio_sync width must be at least one");
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
    if (srst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  assign sync_out = st_reg.stage2;

endmodule // dpio_sync

/* verilog/dpio_top.sv */
// Purpose: Two bidirectional parallel ports with latches and direction registers.
// Assumes: Register port and key wake enables are on sys_clk; pins are asynchronous.
// Notes: Pin driver outputs are registered, so they follow a register write one edge later.
`timescale 1ns/1ps
module dpio_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] key_wake_enable,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  output logic [5:0] key_wake_pullup_en,
  input wire logic [5:0] port_b_in,
  output logic [5:0] port_b_out,
  output logic [5:0] port_b_oe_n
);

  localparam int PA_W = dpio_pkg::PA_W;
  localparam int PB_W = dpio_pkg::PB_W;
  localparam int KW_W = dpio_pkg::KW_W;
  localparam int KW_LO = dpio_pkg::KW_LO;

  typedef struct packed {
    logic [7:0] port_a_latch;
    logic [7:0] port_a_direction;
    logic [5:0] port_b_latch;
    logic [5:0] port_b_direction;
    logic bus_clock_out_enable;
    logic bus_clock_phase;
    logic [7:0] rdata;
    logic [7:0] pa_out;
    logic [7:0] pa_oe_n;
    logic [5:0] pa_pull;
    logic [5:0] pb_out;
    logic [5:0] pb_oe_n;
  } dpio_state_t;

  dpio_state_t st_reg;
  dpio_state_t st_next;

  logic [7:0] pa_pin_sync;
  logic [5:0] pb_pin_sync;
  logic [7:0] pa_force;
  logic [5:0] pb_force;
  logic [7:0] pa_read;
  logic [5:0] pb_read;
  logic [7:0] pa_drive;
  logic [5:0] pb_drive;

  // Maps an address onto a one-hot register select; shared by the write and read paths.
  function automatic dpio_pkg::dpio_sel_t decode_addr(input logic [15:0] addr);
    dpio_pkg::dpio_sel_t sel;
    sel = dpio_pkg::SEL_NONE;
    if (addr == dpio_pkg::OFF_PA_LATCH) begin
      sel = dpio_pkg::SEL_PA_LATCH;
    end else if (addr == dpio_pkg::OFF_PB_LATCH) begin
      sel = dpio_pkg::SEL_PB_LATCH;
    end else if (addr == dpio_pkg::OFF_PA_DIR) begin
      sel = dpio_pkg::SEL_PA_DIR;
    end else if (addr == dpio_pkg::OFF_PB_DIR) begin
      sel = dpio_pkg::SEL_PB_DIR;
    end else begin
      sel = dpio_pkg::SEL_NONE;
    end
    return sel;
  endfunction

  dpio_sync #(
    .W(PA_W)
  ) u_sync_a (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(port_a_in),
    .sync_out(pa_pin_sync)
  );

  dpio_sync #(
    .W(PB_W)
  ) u_sync_b (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(port_b_in),
    .sync_out(pb_pin_sync)
  );

  // Key wake takes over pins 6 down to 1; pins 7 and 0 are never forced.
  always_comb begin
    pa_force = '0;
    pa_force[KW_LO +: KW_W] = key_wake_enable;
  end

  // Pin 0 of port B stops being an ordinary output while the bus clock drives it.
  always_comb begin
    pb_force = '0;
    pb_force[dpio_pkg::BIT_CLK_PIN] = st_reg.bus_clock_out_enable;
  end

  dpio_port_slice #(
    .W(PA_W)
  ) u_slice_a (
    .dir(st_reg.port_a_direction),
    .latch(st_reg.port_a_latch),
    .force_in(pa_force),
    .pin_level(pa_pin_sync),
    .read_val(pa_read),
    .drive_en(pa_drive)
  );

  dpio_port_slice #(
    .W(PB_W)
  ) u_slice_b (
    .dir(st_reg.port_b_direction),
    .latch(st_reg.port_b_latch),
    .force_in(pb_force),
    .pin_level(pb_pin_sync),
    .read_val(pb_read),
    .drive_en(pb_drive)
  );

  always_comb begin
    dpio_pkg::dpio_sel_t wsel;
    dpio_pkg::dpio_sel_t rsel;
    logic [7:0] rmux;
    wsel = dpio_pkg::SEL_NONE;
    rsel = dpio_pkg::SEL_NONE;
    rmux = dpio_pkg::UNMAPPED_RDATA;
    st_next = st_reg;

    // Register writes; a latch takes data whatever its direction bit.
    if (reg_wr) begin
      wsel = decode_addr(reg_addr);
    end
    case (wsel)
      dpio_pkg::SEL_PA_LATCH: begin
        st_next.port_a_latch = reg_wdata;
      end
      dpio_pkg::SEL_PB_LATCH: begin
        st_next.port_b_latch = reg_wdata[PB_W-1:0];
      end
      dpio_pkg::SEL_PA_DIR: begin
        st_next.port_a_direction = reg_wdata;
      end
      dpio_pkg::SEL_PB_DIR: begin
        st_next.port_b_direction = reg_wdata[PB_W-1:0];
        st_next.bus_clock_out_enable = reg_wdata[dpio_pkg::BIT_CLK_OUT_EN];
      end
      default: begin
        st_next.port_a_latch = st_reg.port_a_latch;
      end
    endcase

    // Register reads; data stand in the cycle after the strobe only.
    if (reg_rd) begin
      rsel = decode_addr(reg_addr);
    end
    case (rsel)
      dpio_pkg::SEL_PA_LATCH: begin
        rmux = pa_read;
      end
      dpio_pkg::SEL_PB_LATCH: begin
        rmux = {2'b00, pb_read};
      end
      dpio_pkg::SEL_PA_DIR: begin
        rmux = st_reg.port_a_direction;
      end
      dpio_pkg::SEL_PB_DIR: begin
        rmux = {st_reg.bus_clock_out_enable, 1'b0, st_reg.port_b_direction};
      end
      default: begin
        rmux = dpio_pkg::UNMAPPED_RDATA;
      end
    endcase
    st_next.rdata = rmux;

    // The bus clock image toggles every edge, giving half the system clock on the pin.
    st_next.bus_clock_phase = ~st_reg.bus_clock_phase;

    // Port A drivers: latch value while the direction bit is 1 and key wake is off.
    for (int i = 0; i < PA_W; i++) begin
      st_next.pa_out[i] = pa_drive[i] & st_reg.port_a_latch[i];
      st_next.pa_oe_n[i] = ~pa_drive[i];
    end
    st_next.pa_pull = key_wake_enable;

    // Port B drivers, with pin 0 given over to the bus clock when enabled.
    for (int i = 0; i < PB_W; i++) begin
      st_next.pb_out[i] = pb_drive[i] & st_reg.port_b_latch[i];
      st_next.pb_oe_n[i] = ~pb_drive[i];
    end
    if (st_reg.bus_clock_out_enable) begin
      st_next.pb_out[dpio_pkg::BIT_CLK_PIN] = st_reg.bus_clock_phase;
      st_next.pb_oe_n[dpio_pkg::BIT_CLK_PIN] = 1'b0;
    end

    // Reset clears control and outputs but leaves both data latches alone.
    if (srst) begin
      st_next.port_a_latch = st_reg.port_a_latch;
      st_next.port_b_latch = st_reg.port_b_latch;
      st_next.port_a_direction = dpio_pkg::RST_PA_DIR;
      st_next.port_b_direction = dpio_pkg::RST_PB_DIR;
      st_next.bus_clock_out_enable = dpio_pkg::RST_CLK_OUT_EN;
      st_next.bus_clock_phase = 1'b0;
      st_next.rdata = dpio_pkg::RST_RDATA;
      st_next.pa_out = '0;
      st_next.pa_oe_n = '1;
      st_next.pa_pull = '0;
      st_next.pb_out = '0;
      st_next.pb_oe_n = '1;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign port_a_out = st_reg.pa_out;
  assign port_a_oe_n = st_reg.pa_oe_n;
  assign key_wake_pullup_en = st_reg.pa_pull;
  assign port_b_out = st_reg.pb_out;
  assign port_b_oe_n = st_reg.pb_oe_n;

endmodule // dpio_top
